//--- include/pieg_pkg.sv
package pieg_pkg;

    // Byte addresses of the registers on the Wishbone slave
    localparam logic [7:0] OFS_CTRL      = 8'h08;
    localparam logic [7:0] OFS_FLAGS     = 8'h0C;
    localparam logic [7:0] OFS_FLAGS_CLR = 8'h10;
    localparam logic [7:0] OFS_ENABLE    = 8'h8C;

    // Source positions, shared by the enable and flag registers
    localparam int BIT_NVM_DONE  = 7;
    localparam int BIT_ADC_DONE  = 6;
    localparam int BIT_CAPCMP    = 5;
    localparam int BIT_UNUSED    = 4;
    localparam int BIT_CMP_CHG   = 3;
    localparam int BIT_OSC_FAIL  = 2;
    localparam int BIT_TMR2_MTCH = 1;
    localparam int BIT_TMR1_OVF  = 0;

    // Positions in the core interrupt control register
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN  = 6;

    // Implemented bits; bit 4 of the source registers does not exist
    localparam logic [7:0] SRC_MASK  = 8'hEF;
    localparam logic [7:0] CTRL_MASK = 8'hC0;

    // Values after reset
    localparam logic [7:0]  ENABLE_RST = 8'h00;
    localparam logic [7:0]  FLAGS_RST  = 8'h00;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

    // Bus answer sequencer, gray coded
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } pieg_bus_state_t;

endpackage : pieg_pkg

//--- hw/pieg_flag_bank.sv
// Sticky event flags, one per peripheral source
module pieg_flag_bank (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] event_i,
    input  wire logic       wr_i,
    input  wire logic       clr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] flags_o
);

    logic [7:0] flags;
    logic [7:0] next_flags;

    // Software write or clear first, then events on top so a set wins
    always_comb begin
        next_flags = flags;
        if (wr_i) begin
            next_flags = wdata_i & pieg_pkg::SRC_MASK;
        end
        if (clr_i) begin
            next_flags = flags & ~wdata_i;
        end
        next_flags = next_flags | (event_i & pieg_pkg::SRC_MASK);
    end

    // Hardware never drops a flag by itself, only software does
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flags <= pieg_pkg::FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    assign flags_o = flags;

endmodule : pieg_flag_bank

//--- hw/pieg_top.sv
// What this block does
// - No peripheral request without group enable
// - Enable register at 8Ch, resets to zero
// - Bit 7 gates nonvolatile write complete
// - Bit 6 gates converter completion
// - Bit 0 gates timer one overflow
// - Flags set regardless of any enable
// - Flag register mirrors enable bit layout
// - Group enable passes every enabled request
module pieg_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  periph_event_i,
    output logic             periph_irq_o,
    output logic             irq_o
);

    // Word decode of a byte address against a register offset
    // Bits [1:0] are ignored, so byte aliases of one word all hit
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // Bus sequencer state
    pieg_pkg::pieg_bus_state_t state;
    pieg_pkg::pieg_bus_state_t next_state;
    logic                      ack;
    logic                      next_ack;
    logic [31:0]               rdata;
    logic [31:0]               next_rdata;

    // Software visible registers
    logic [7:0] enable;
    logic [7:0] next_enable;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] flags;

    // Write strobes, one cycle each
    logic       wr_go;
    logic       wr_enable;
    logic       wr_ctrl;
    logic       wr_flags;
    logic       clr_flags;

    // Interrupt outputs
    logic       pending;
    logic       next_pending;
    logic       irq;
    logic       next_irq;

    // A write lands on the edge where the master sees ack
    assign wr_go     = (state == pieg_pkg::BUS_ACK) && wb_cyc_i
                       && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign wr_enable = wr_go && hit(wb_adr_i, pieg_pkg::OFS_ENABLE);
    assign wr_ctrl   = wr_go && hit(wb_adr_i, pieg_pkg::OFS_CTRL);
    assign wr_flags  = wr_go && hit(wb_adr_i, pieg_pkg::OFS_FLAGS);
    assign clr_flags = wr_go && hit(wb_adr_i, pieg_pkg::OFS_FLAGS_CLR);

    // Bus answer: one wait state, ack for one cycle, then idle again
    always_comb begin
        next_state = state;
        next_ack   = 1'b0;
        next_rdata = pieg_pkg::RDATA_RST;
        case (state)
            pieg_pkg::BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    next_state = pieg_pkg::BUS_ACK;
                    next_ack   = 1'b1;
                    // Unmapped addresses still answer, reading zero
                    if (hit(wb_adr_i, pieg_pkg::OFS_ENABLE)) begin
                        next_rdata = {24'h00_0000, enable};
                    end else if (hit(wb_adr_i, pieg_pkg::OFS_FLAGS)
                                 || hit(wb_adr_i,
                                        pieg_pkg::OFS_FLAGS_CLR)) begin
                        next_rdata = {24'h00_0000, flags};
                    end else if (hit(wb_adr_i, pieg_pkg::OFS_CTRL)) begin
                        next_rdata = {24'h00_0000, ctrl};
                    end
                end
            end
            pieg_pkg::BUS_ACK: begin
                next_state = pieg_pkg::BUS_IDLE;
            end
            default: begin
                next_state = pieg_pkg::BUS_IDLE;
            end
        endcase
    end

    // Bus registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state <= pieg_pkg::BUS_IDLE;
            ack   <= 1'b0;
            rdata <= pieg_pkg::RDATA_RST;
        end else begin
            state <= next_state;
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    // Enable and control writes; the missing bit 4 never stores
    always_comb begin
        next_enable = enable;
        next_ctrl   = ctrl;
        if (wr_enable) begin
            next_enable = wb_dat_i[7:0] & pieg_pkg::SRC_MASK;
        end
        if (wr_ctrl) begin
            next_ctrl = wb_dat_i[7:0] & pieg_pkg::CTRL_MASK;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            enable <= pieg_pkg::ENABLE_RST;
            ctrl   <= pieg_pkg::CTRL_RST;
        end else begin
            enable <= next_enable;
            ctrl   <= next_ctrl;
        end
    end

    // Event flags share the enable layout bit for bit
    pieg_flag_bank u_flags (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .event_i   (periph_event_i),
        .wr_i      (wr_flags),
        .clr_i     (clr_flags),
        .wdata_i   (wb_dat_i[7:0]),
        .flags_o   (flags)
    );

    // Request gating: per-source enable, then group, then global.
    // A stale flag fires as soon as its enable is set, so software
    // should clear it first; the hardware does not hide it.
    always_comb begin
        next_pending = ctrl[pieg_pkg::BIT_GROUP_EN]
                       && |(flags & enable);
        next_irq     = next_pending && ctrl[pieg_pkg::BIT_GLOBAL_EN];
    end

    // Outputs straight from flops, one cycle behind the registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pending <= 1'b0;
            irq     <= 1'b0;
        end else begin
            pending <= next_pending;
            irq     <= next_irq;
        end
    end

    assign wb_ack_o     = ack;
    assign wb_dat_o     = rdata;
    assign periph_irq_o = pending;
    assign irq_o        = irq;

    // Checks, all on the system clock and masked during reset except a_enable_reset
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // A write that the master completes at this edge
    sequence s_bus_write(logic [7:0] ofs);
        wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o
        && hit(wb_adr_i, ofs);
    endsequence

    // A single source flagged and enabled with the group open
    sequence s_only_source(int b);
        ((flags & enable) == (8'h01 << b))
        && ctrl[pieg_pkg::BIT_GROUP_EN];
    endsequence

    a_enable_reset: assert property (
        @(posedge clk_sys_i) disable iff (1'b0)
        !rst_n_i |=> (enable == pieg_pkg::ENABLE_RST))
        else $error("enable register not cleared by reset");

    a_enable_write: assert property (
        s_bus_write(pieg_pkg::OFS_ENABLE) |=>
        (enable == ($past(wb_dat_i[7:0]) & pieg_pkg::SRC_MASK)))
        else $error("enable register write lost");

    a_group_gate: assert property (
        periph_irq_o |-> $past(ctrl[pieg_pkg::BIT_GROUP_EN]))
        else $error("peripheral request with group enable off");

    a_group_pass: assert property (
        (ctrl[pieg_pkg::BIT_GROUP_EN] && |(flags & enable))
        |=> periph_irq_o)
        else $error("enabled request not passed by open group");

    a_nvm_gate: assert property (
        s_only_source(pieg_pkg::BIT_NVM_DONE) |=> periph_irq_o)
        else $error("nvm write done request not passed");

    a_adc_gate: assert property (
        s_only_source(pieg_pkg::BIT_ADC_DONE) |=> periph_irq_o)
        else $error("converter done request not passed");

    a_tmr1_block: assert property (
        (!enable[pieg_pkg::BIT_TMR1_OVF]
         && ((flags & enable) == 8'h00)) |=> !periph_irq_o)
        else $error("timer one overflow passed while disabled");

    a_flag_sets: assert property (
        |(periph_event_i & pieg_pkg::SRC_MASK) |=>
        ((flags & $past(periph_event_i) & pieg_pkg::SRC_MASK)
         == ($past(periph_event_i) & pieg_pkg::SRC_MASK)))
        else $error("event did not set its flag");

    a_flag_holds: assert property (
        |(~flags & $past(flags)) |->
        ($past(wr_flags) || $past(clr_flags)))
        else $error("flag dropped without a software write");

    a_bit4_absent: assert property (
        !enable[pieg_pkg::BIT_UNUSED] && !flags[pieg_pkg::BIT_UNUSED])
        else $error("unimplemented bit 4 holds a one");

    a_irq_global: assert property (
        irq_o |-> $past(ctrl[pieg_pkg::BIT_GLOBAL_EN]) && periph_irq_o)
        else $error("interrupt without global enable");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Bus answer timing; the master may count on exactly one wait
    // state, and a_ack_latency flags any slower answer to a taken request
    sequence s_bus_take;
        (state == pieg_pkg::BUS_IDLE) && wb_cyc_i && wb_stb_i;
    endsequence

    // A write that completes with the low byte lane switched off
    sequence s_bus_no_lane;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0] && wb_ack_o;
    endsequence

    a_ack_latency: assert property (
        s_bus_take |=> wb_ack_o)
        else $error("request not answered after one wait state");

    // Read data is zero outside the ack cycle, so slaves may be ORed
    a_rdata_quiet: assert property (
        !wb_ack_o |-> (wb_dat_o == pieg_pkg::RDATA_RST))
        else $error("read data driven outside the ack cycle");

    // Registers are one byte wide; upper lanes always read zero
    a_rdata_upper: assert property (
        wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data above the register byte");

    // Control writes keep only the two enable bits
    a_ctrl_write: assert property (
        s_bus_write(pieg_pkg::OFS_CTRL) |=>
        (ctrl == ($past(wb_dat_i[7:0]) & pieg_pkg::CTRL_MASK)))
        else $error("control register write lost");

    // Without the low lane a write must leave enable and ctrl alone
    a_lane_guard: assert property (
        s_bus_no_lane |=> ($stable(enable) && $stable(ctrl)))
        else $error("write without byte lane changed a register");

    // Flag writes: the stored value plus any event of the same cycle
    a_flags_write: assert property (
        s_bus_write(pieg_pkg::OFS_FLAGS) |=>
        (flags == (($past(wb_dat_i[7:0]) | $past(periph_event_i))
                   & pieg_pkg::SRC_MASK)))
        else $error("flag register write lost");

    a_clear_lands: assert property (
        s_bus_write(pieg_pkg::OFS_FLAGS_CLR) |=>
        ((flags & $past(wb_dat_i[7:0]) & ~$past(periph_event_i))
         == 8'h00))
        else $error("flag clear by writing one did not land");

    // Blocking side of the per-source gates: no request without a
    // source that is both flagged and enabled
    a_src_needed: assert property (
        periph_irq_o |-> $past(|(flags & enable)))
        else $error("peripheral request with no enabled flag");

    a_group_block: assert property (
        !ctrl[pieg_pkg::BIT_GROUP_EN] |=> !periph_irq_o)
        else $error("request passed while group enable is off");

endmodule : pieg_top

//--- verif/pieg_src_model.sv
// Peripheral event sources on the far side of the gating block
module pieg_src_model (
    input  wire logic       clk_sys_i,
    output logic      [7:0] event_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle sources hold the event lines low
    initial begin
        event_o = 8'h00;
    end

    // One-cycle event pulse, as a peripheral raises it
    task automatic pulse(input logic [7:0] mask);
        @(posedge clk_sys_i) event_o <= mask;
        @(posedge clk_sys_i) event_o <= 8'h00;
    endtask : pulse
endmodule : pieg_src_model

//--- verif/peripheral_irq_enable_gating_tb.sv
// Register bus and event checks of the peripheral gating block
module peripheral_irq_enable_gating_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys_i;
    logic        rst_n_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [7:0]  events;
    logic        periph_irq;
    logic        irq;
    logic [31:0] v;
    int          fail_count;
    int          checked;

    pieg_top dut (
        .clk_sys_i      (clk_sys_i),
        .rst_n_i        (rst_n_i),
        .wb_cyc_i       (cyc),
        .wb_stb_i       (stb),
        .wb_we_i        (we),
        .wb_adr_i       (adr),
        .wb_sel_i       (sel),
        .wb_dat_i       (wdat),
        .wb_dat_o       (rdat),
        .wb_ack_o       (ack),
        .periph_event_i (events),
        .periph_irq_o   (periph_irq),
        .irq_o          (irq)
    );

    pieg_src_model src (
        .clk_sys_i (clk_sys_i),
        .event_o   (events)
    );

    // 100 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Classic single cycle; waits for ack, only the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_sys_i);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, 4'hf, r);
    endtask : wr

    // Outputs are levels; they are compared three cycles later
    task automatic chk_irq(input logic p, input logic g);
        repeat (3) @(posedge clk_sys_i);
        chk("irq pair", {30'h0, periph_irq, irq}, {30'h0, p, g});
    endtask : chk_irq

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        logic [7:0] m;
        fail_count = 0;
        checked = 0;
        rst_n_i = 1'b0;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        wb(1'b0, pieg_pkg::OFS_ENABLE, 32'h0, 4'hf, v);
        chk("enable reset", v, 32'h0000_0000);
        wb(1'b0, pieg_pkg::OFS_FLAGS, 32'h0, 4'hf, v);
        chk("flags reset", v, 32'h0000_0000);
        wr(pieg_pkg::OFS_ENABLE, 32'h0000_00FF);
        wb(1'b0, pieg_pkg::OFS_ENABLE, 32'h0, 4'h0, v);
        wb(1'b1, pieg_pkg::OFS_ENABLE, 32'h0, 4'h0, v);
        wb(1'b0, pieg_pkg::OFS_ENABLE, 32'h0, 4'hf, v);
        chk("enable bits", v, 32'h0000_00EF);
        wb(1'b0, 8'h40, 32'h0, 4'hf, v);
        chk("unmapped", v, 32'h0000_0000);
        wr(pieg_pkg::OFS_CTRL, 32'h0000_00FF);
        wb(1'b0, pieg_pkg::OFS_CTRL, 32'h0, 4'hf, v);
        chk("ctrl bits", v, 32'h0000_00C0);
        // All enables off: events must still raise their flags
        wr(pieg_pkg::OFS_CTRL, 32'h0000_0000);
        wr(pieg_pkg::OFS_ENABLE, 32'h0000_0000);
        src.pulse(8'hFF);
        wb(1'b0, pieg_pkg::OFS_FLAGS_CLR, 32'h0, 4'hf, v);
        chk("flags ungated", v, 32'h0000_00EF);
        wr(pieg_pkg::OFS_FLAGS_CLR, 32'h0000_00FF);
        wr(pieg_pkg::OFS_FLAGS, 32'h0000_00FF);
        wb(1'b0, pieg_pkg::OFS_FLAGS, 32'h0, 4'hf, v);
        chk("flags written", v, 32'h0000_00EF);
        wr(pieg_pkg::OFS_FLAGS, 32'h0000_0000);
        wr(pieg_pkg::OFS_ENABLE, 32'h0000_00FF);
        // Global on, group off: flags rise but nothing reaches the core
        wr(pieg_pkg::OFS_CTRL, 32'h0000_0080);
        src.pulse(8'hFF);
        chk_irq(1'b0, 1'b0);
        repeat (4) @(posedge clk_sys_i);
        wb(1'b0, pieg_pkg::OFS_FLAGS, 32'h0, 4'hf, v);
        chk("flags sticky", v, 32'h0000_00EF);
        wr(pieg_pkg::OFS_FLAGS_CLR, 32'h0000_00FF);
        wb(1'b0, pieg_pkg::OFS_FLAGS, 32'h0, 4'hf, v);
        chk("flags cleared", v, 32'h0000_0000);
        // Each source alone: only its own enable lets it through
        for (int b = 0; b < 8; b++) begin
            if (b == pieg_pkg::BIT_UNUSED) continue;
            m = 8'h01 << b;
            wr(pieg_pkg::OFS_CTRL, 32'h0000_0000);
            wr(pieg_pkg::OFS_ENABLE, {24'h0, m});
            wr(pieg_pkg::OFS_CTRL, 32'h0000_00C0);
            src.pulse(pieg_pkg::SRC_MASK & ~m);
            chk_irq(1'b0, 1'b0);
            src.pulse(m);
            chk_irq(1'b1, 1'b1);
            wr(pieg_pkg::OFS_CTRL, 32'h0000_0040);
            chk_irq(1'b1, 1'b0);
            wr(pieg_pkg::OFS_CTRL, 32'h0000_0080);
            chk_irq(1'b0, 1'b0);
            wr(pieg_pkg::OFS_FLAGS, 32'h0000_0000);
            wr(pieg_pkg::OFS_CTRL, 32'h0000_00C0);
            chk_irq(1'b0, 1'b0);
        end
        // Reset in mid-run drops the request and clears enable and flags
        wr(pieg_pkg::OFS_ENABLE, 32'h0000_00FF);
        src.pulse(8'hFF);
        chk_irq(1'b1, 1'b1);
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        chk_irq(1'b0, 1'b0);
        wb(1'b0, pieg_pkg::OFS_ENABLE, 32'h0, 4'hf, v);
        chk("enable after reset", v, 32'h0000_0000);
        wb(1'b0, pieg_pkg::OFS_FLAGS, 32'h0, 4'hf, v);
        chk("flags after reset", v, 32'h0000_0000);
        summarize();
    end

    // Watchdog; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        summarize();
    end
endmodule : peripheral_irq_enable_gating_tb
